/* ptm_pkg.sv */
package ptm_pkg;
   localparam int unsigned CNT_W = 10;
   // wishbone word offsets (byte addresses)
   localparam logic [4:0] OFS_CTRL0   = 5'h00;
   localparam logic [4:0] OFS_CTRL1   = 5'h04;
   localparam logic [4:0] OFS_CNT_LO  = 5'h08;
   localparam logic [4:0] OFS_CNT_HI  = 5'h0C;
   localparam logic [4:0] OFS_CMPA_LO = 5'h10;
   localparam logic [4:0] OFS_CMPA_HI = 5'h14;
   localparam logic [4:0] OFS_PER_LO  = 5'h18;
   localparam logic [4:0] OFS_PER_HI  = 5'h1C;
   // control0 fields
   localparam int unsigned CTRL0_PAUSE_BIT = 7;
   localparam int unsigned CTRL0_ON_BIT    = 3;
   localparam int unsigned CTRL0_TICK_BIT  = 0;
   // control1 fields
   localparam int unsigned CTRL1_MODE_HI   = 7;
   localparam int unsigned CTRL1_FUNC_HI   = 5;
   localparam int unsigned CTRL1_LEVEL_BIT = 3;
   localparam int unsigned CTRL1_INV_BIT   = 2;
   localparam int unsigned CTRL1_CLR_BIT   = 0;
   // status fields
   localparam int unsigned STAT_A_BIT = 0;
   localparam int unsigned STAT_P_BIT = 1;
   localparam logic [5:0] OFS_STATUS  = 6'h20;
   localparam logic [5:0] ADDR_TOP    = 6'h24;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [9:0] CNT_MAX     = 10'h3FF;
   localparam logic [1:0] MODE_CMP    = 2'h0;
   localparam logic [1:0] MODE_PWM    = 2'h2;
   localparam logic [1:0] MODE_TMR    = 2'h3;
   localparam logic [1:0] FUNC_NONE   = 2'h0;
   localparam logic [1:0] FUNC_LOW    = 2'h1;
   localparam logic [1:0] FUNC_HIGH   = 2'h2;
   localparam logic [1:0] FUNC_TOGGLE = 2'h3;
endpackage

/* periodic_timer_compare_pwm.sv */
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// How it works
// - count readable as low byte, high bits
// - compare a split low byte, high bits
// - compare p split low byte, high bits
// - unused high bits read zero, reset zero
// - mode field picks compare, timer, pwm
// - clear-source low: clear on p, both flags
// - clear-source high: clear on a, a only
// - a zero: run to 3FF, no a flag
// - pin changes only on a match or on rise
// - a match drives high, low or toggles
// - counter_on rise loads initial level
// - timer mode counts but leaves pin alone
// - pwm clears on p, a sets duty
// - period is p, or 1024 when zero
// - a at or above period: full duty
// - pwm raises a and p flags
// - pwm level, force and invert controls
// - pwm counting continues while forced
// - on rise clears counter, off holds it
// - pause holds count, resume continues
// - function codes none, low, high, toggle
module periodic_timer_compare_pwm
   import ptm_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        count_tick_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [5:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   output logic             wb_err_out,
   output logic             timer_pin_out,
   output logic             timer_pin_oe_out,
   output logic             match_a_pulse_out,
   output logic             match_p_pulse_out
);
   logic [7:0]       timer_control_0_reg;
   logic [7:0]       timer_control_1_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] compare_a_value_reg;
   logic [CNT_W-1:0] compare_p_value_reg;
   logic             match_a_flag_reg;
   logic             match_p_flag_reg;
   logic             on_prev_reg;
   logic             cmp_pin_reg;
   logic             pwm_active_reg;
   logic             ack_reg;
   logic [31:0]      rdata_reg;

   logic       req;
   logic       mapped;
   logic       wr_ok;
   logic       counter_on;
   logic       counter_pause;
   logic [1:0] op_mode;
   logic [1:0] out_func;
   logic       clear_source_sel;
   logic       out_initial_level;
   logic       out_invert;
   logic       on_rise;
   logic       advance;
   logic       hit_a;
   logic       hit_p;
   logic       at_max;
   logic       clear_now;
   logic       ev_a;
   logic       ev_p;
   logic       cmp_like;
   logic       clr_a_flag;
   logic       clr_p_flag;
   logic [7:0] wbyte;

   function automatic logic [7:0] hi_bits(input logic [CNT_W-1:0] v);
      hi_bits = {6'h00, v[9:8]};
   endfunction

   assign counter_on        = timer_control_0_reg[CTRL0_ON_BIT];
   assign counter_pause     = timer_control_0_reg[CTRL0_PAUSE_BIT];
   assign op_mode           = timer_control_1_reg[CTRL1_MODE_HI -: 2];
   assign out_func          = timer_control_1_reg[CTRL1_FUNC_HI -: 2];
   assign out_initial_level = timer_control_1_reg[CTRL1_LEVEL_BIT];
   assign out_invert        = timer_control_1_reg[CTRL1_INV_BIT];
   assign clear_source_sel  = timer_control_1_reg[CTRL1_CLR_BIT];

   // classic wishbone slave, one wait state answer
   assign req    = wb_cyc_in & wb_stb_in & ~ack_reg;
   assign mapped = (wb_adr_in < ADDR_TOP) && (wb_adr_in[1:0] == 2'h0);
   assign wr_ok  = req & wb_we_in & mapped & wb_sel_in[0];
   assign wbyte  = wb_dat_in[7:0];
   assign wb_ack_out = ack_reg & mapped;
   assign wb_err_out = ack_reg & ~mapped;
   assign wb_dat_out = rdata_reg;

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_cyc_in & wb_stb_in & ~ack_reg;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         rdata_reg <= 32'h00000000;
      end else if (req && !wb_we_in) begin
         rdata_reg <= 32'h00000000;
         unique case (wb_adr_in[5:0])
            {1'b0, OFS_CTRL0}:   rdata_reg[7:0] <= timer_control_0_reg;
            {1'b0, OFS_CTRL1}:   rdata_reg[7:0] <= timer_control_1_reg;
            {1'b0, OFS_CNT_LO}:  rdata_reg[7:0] <= count_reg[7:0];
            {1'b0, OFS_CNT_HI}:  rdata_reg[7:0] <= hi_bits(count_reg);
            {1'b0, OFS_CMPA_LO}: rdata_reg[7:0] <= compare_a_value_reg[7:0];
            {1'b0, OFS_CMPA_HI}: rdata_reg[7:0] <= hi_bits(compare_a_value_reg);
            {1'b0, OFS_PER_LO}:  rdata_reg[7:0] <= compare_p_value_reg[7:0];
            {1'b0, OFS_PER_HI}:  rdata_reg[7:0] <= hi_bits(compare_p_value_reg);
            OFS_STATUS:          rdata_reg[1:0] <= {match_p_flag_reg,
                                                    match_a_flag_reg};
            default:             rdata_reg[7:0] <= 8'h00;
         endcase
      end
   end

   // one strobe per register keeps the address decode in one place
   function automatic logic at_ofs(input logic [5:0] adr,
                                   input logic [5:0] ofs);
      at_ofs = (adr == ofs);
   endfunction

   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_a_lo;
   logic wr_a_hi;
   logic wr_p_lo;
   logic wr_p_hi;
   logic wr_status;

   assign wr_ctrl0  = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_CTRL0});
   assign wr_ctrl1  = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_CTRL1});
   assign wr_a_lo   = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_CMPA_LO});
   assign wr_a_hi   = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_CMPA_HI});
   assign wr_p_lo   = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_PER_LO});
   assign wr_p_hi   = wr_ok && at_ofs(wb_adr_in, {1'b0, OFS_PER_HI});
   assign wr_status = wr_ok && at_ofs(wb_adr_in, OFS_STATUS);

   // control0: low three bits unimplemented, kept zero
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         timer_control_0_reg <= CTRL0_RESET;
      end else if (wr_ctrl0) begin
         timer_control_0_reg <= {wbyte[7:3], 3'h0};
      end
   end

   // mode changes while running are not blocked; stop the timer first
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         timer_control_1_reg <= CTRL1_RESET;
      end else if (wr_ctrl1) begin
         timer_control_1_reg <= wbyte;
      end
   end

   // halves written independently, no latching: a split update
   // can be seen by a running compare until the other half is written
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         compare_a_value_reg[7:0] <= 8'h00;
      end else if (wr_a_lo) begin
         compare_a_value_reg[7:0] <= wbyte;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         compare_a_value_reg[9:8] <= 2'h0;
      end else if (wr_a_hi) begin
         compare_a_value_reg[9:8] <= wbyte[1:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         compare_p_value_reg[7:0] <= 8'h00;
      end else if (wr_p_lo) begin
         compare_p_value_reg[7:0] <= wbyte;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         compare_p_value_reg[9:8] <= 2'h0;
      end else if (wr_p_hi) begin
         compare_p_value_reg[9:8] <= wbyte[1:0];
      end
   end

   // counter core
   assign on_rise  = counter_on & ~on_prev_reg;
   assign advance  = counter_on & ~counter_pause & count_tick_in;
   assign cmp_like = (op_mode == MODE_CMP) || (op_mode == MODE_TMR);
   assign at_max   = (count_reg == CNT_MAX);
   // matches are seen as the counter leaves the value one below compare
   assign hit_a = advance && (compare_a_value_reg != 10'h000)
                  && (count_reg == compare_a_value_reg - 10'h001);
   assign hit_p = advance && ((compare_p_value_reg == 10'h000) ? at_max
                  : (count_reg == compare_p_value_reg - 10'h001));

   always_comb begin
      clear_now = 1'b0;
      ev_a      = 1'b0;
      ev_p      = 1'b0;
      if (cmp_like) begin
         if (clear_source_sel) begin
            clear_now = hit_a | (advance & at_max);
            ev_a      = hit_a;
         end else begin
            clear_now = hit_p;
            ev_a      = hit_a;
            ev_p      = hit_p;
         end
      end else if (op_mode == MODE_PWM) begin
         clear_now = hit_p;
         ev_a      = hit_a;
         ev_p      = hit_p;
      end else begin
         clear_now = advance & at_max;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         on_prev_reg <= 1'b0;
      end else begin
         on_prev_reg <= counter_on;
      end
   end

   // restart wins over clear, clear over advance
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         count_reg   <= 10'h000;
      end else begin
         if (on_rise) begin
            count_reg <= 10'h000;
         end else if (clear_now) begin
            count_reg <= 10'h000;
         end else if (advance) begin
            count_reg <= count_reg + 10'h001;
         end
      end
   end

   // flags: status write of one clears; a new event wins over the clear
   assign clr_a_flag = wr_status && wbyte[STAT_A_BIT];
   assign clr_p_flag = wr_status && wbyte[STAT_P_BIT];

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         match_a_flag_reg <= 1'b0;
      end else begin
         match_a_flag_reg <= ev_a | (match_a_flag_reg & ~clr_a_flag);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         match_p_flag_reg <= 1'b0;
      end else begin
         match_p_flag_reg <= ev_p | (match_p_flag_reg & ~clr_p_flag);
      end
   end

   // pulses rise on the same edge as the flags and come from flip-flops
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         match_a_pulse_out <= 1'b0;
      end else begin
         match_a_pulse_out <= ev_a;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         match_p_pulse_out <= 1'b0;
      end else begin
         match_p_pulse_out <= ev_p;
      end
   end

   // compare-match pin state
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         cmp_pin_reg <= 1'b0;
      end else if (on_rise) begin
         cmp_pin_reg <= out_initial_level;
      end else if (op_mode == MODE_CMP && ev_a) begin
         unique case (out_func)
            FUNC_NONE:   cmp_pin_reg <= cmp_pin_reg;
            FUNC_LOW:    cmp_pin_reg <= 1'b0;
            FUNC_HIGH:   cmp_pin_reg <= 1'b1;
            FUNC_TOGGLE: cmp_pin_reg <= ~cmp_pin_reg;
         endcase
      end
   end

   // pwm active phase from next count value
   logic [CNT_W-1:0] count_next;
   logic [10:0]      period;
   always_comb begin
      count_next = count_reg;
      if (on_rise || clear_now) begin
         count_next = 10'h000;
      end else if (advance) begin
         count_next = count_reg + 10'h001;
      end
      period = (compare_p_value_reg == 10'h000) ? 11'h400
               : {1'b0, compare_p_value_reg};
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         pwm_active_reg <= 1'b0;
      end else begin
         pwm_active_reg <= ({1'b0, compare_a_value_reg} >= period)
                           || (count_next < compare_a_value_reg);
      end
   end

   // output pin: timer mode releases it; pwm forcing and invert
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         timer_pin_oe_out <= 1'b0;
      end else begin
         timer_pin_oe_out <= (op_mode == MODE_CMP) || (op_mode == MODE_PWM);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         timer_pin_out    <= 1'b0;
      end else begin
         if (op_mode == MODE_PWM) begin
            unique case (out_func)
               FUNC_NONE: timer_pin_out <= ~out_initial_level ^ out_invert;
               FUNC_LOW:  timer_pin_out <= out_initial_level ^ out_invert;
               default:   timer_pin_out <= (pwm_active_reg
                                 ? out_initial_level : ~out_initial_level)
                                 ^ out_invert;
            endcase
         end else if (op_mode == MODE_CMP) begin
            timer_pin_out <= cmp_pin_reg ^ out_invert;
         end else begin
            timer_pin_out <= 1'b0;
         end
      end
   end
endmodule

/* ptm_checker.sv */
`timescale 1ns/1ps
module ptm_checker
   import ptm_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        reset_n_in,
   input wire logic        count_tick_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [5:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        wb_err_out,
   input wire logic        match_a_pulse_out,
   input wire logic        match_p_pulse_out
);
   logic req;
   logic bad;
   logic rd;
   assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
   assign bad = (wb_adr_in >= ADDR_TOP) || (wb_adr_in[1:0] != 2'h0);
   assign rd = wb_ack_out && !wb_we_in;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_bus_answer:
   assert property (req && !bad |=> wb_ack_out && !wb_err_out)
      else $error("mapped access not acked");
   a_bus_refuse:
   assert property (req && bad |=> wb_err_out && !wb_ack_out)
      else $error("unmapped access not refused");
   a_ack_single:
   assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_cause:
   assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
      else $error("ack without request");
   a_read_top_zero:
   assert property (rd |-> wb_dat_out[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_high_bits_zero:
   assert property (rd && wb_adr_in inside {6'h0C, 6'h14, 6'h1C}
                    |-> wb_dat_out[7:2] == 6'h00)
      else $error("unused high bits not zero");
   a_match_a_tick:
   assert property (match_a_pulse_out |-> $past(count_tick_in))
      else $error("match a without tick");
   a_match_p_tick:
   assert property (match_p_pulse_out |-> $past(count_tick_in))
      else $error("match p without tick");
   a_match_a_once:
   assert property (match_a_pulse_out |=> !match_a_pulse_out)
      else $error("match a twice in a row");
endmodule

bind periodic_timer_compare_pwm ptm_checker chk (
   .mclk_in(mclk_in), .reset_n_in(reset_n_in),
   .count_tick_in(count_tick_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .wb_err_out(wb_err_out), .match_a_pulse_out(match_a_pulse_out),
   .match_p_pulse_out(match_p_pulse_out));

/* test_periodic_timer_compare_pwm.sv */
`timescale 1ns/1ps
module test_periodic_timer_compare_pwm;
   import ptm_pkg::*;
   logic        mclk_in, reset_n_in, count_tick_in, wb_cyc_in, wb_stb_in;
   logic        wb_we_in, wb_ack_out, wb_err_out, timer_pin_out;
   logic        timer_pin_oe_out, match_a_pulse_out, match_p_pulse_out;
   logic        lvl, pe;
   logic [5:0]  wb_adr_in, b;
   logic [3:0]  wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [9:0]  v;
   logic [7:0]  d;
   int          failures, n_checks, n, hi;
   periodic_timer_compare_pwm uut (
      .mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .count_tick_in(count_tick_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
      .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .wb_err_out(wb_err_out), .timer_pin_out(timer_pin_out),
      .timer_pin_oe_out(timer_pin_oe_out),
      .match_a_pulse_out(match_a_pulse_out),
      .match_p_pulse_out(match_p_pulse_out));
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] ex);
      n_checks++;
      if (got !== ex) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
      end
   endtask
   // negedge: ack and read data have settled by then
   always @(negedge mclk_in) begin
      if ((wb_ack_out || wb_err_out) && wb_cyc_in && !wb_we_in) begin
         e = exp_q.pop_front();
         if (e[32])
            chk({wb_err_out, 32'h0}, e);
         else
            chk({wb_err_out, wb_dat_out}, e);
      end
   end
   task automatic wb(input logic w, input logic [5:0] a,
                     input logic [7:0] x, input logic [32:0] ex);
      n = 0;
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= {24'h0, x};
      if (!w)
         exp_q.push_back(ex);
      do begin
         @(posedge mclk_in);
         n++;
      end while (!(wb_ack_out || wb_err_out) && n < 50);
      if (n >= 50) begin
         failures++;
         results();
      end
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] x);
      wb(1'b1, a, x, 33'h0);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] x);
      wb(1'b0, a, 8'h00, {25'h0, x});
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge mclk_in) count_tick_in <= 1'b1;
      @(posedge mclk_in) count_tick_in <= 1'b0;
   endtask
   // off then on, so each run starts from a cleared count
   task automatic cfg(input logic [7:0] c1);
      wr(6'h00, 8'h00);
      wr(6'h04, c1);
      wr(6'h00, 8'h08);
      wr(6'h20, 8'h03);
   endtask
   task automatic duty(input logic [7:0] c1, input int ex);
      cfg(c1);
      count_tick_in <= 1'b1;
      repeat (8) @(posedge mclk_in);
      hi = 0;
      repeat (40) @(posedge mclk_in) hi += timer_pin_out;
      count_tick_in <= 1'b0;
      chk(33'(hi), 33'(ex));
   endtask
   initial begin
      {reset_n_in, count_tick_in, wb_cyc_in, wb_stb_in, wb_we_in} = 5'h00;
      wb_adr_in = 6'h00;
      wb_sel_in <= 4'hF;
      wb_dat_in = 32'h0;
      failures = 0;
      n_checks = 0;
      void'($urandom(4204));
      repeat (20) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      for (int i = 2; i < 8; i++) rd(6'(i * 4), 8'h00);
      wb(1'b0, 6'h24, 8'h00, {1'b1, 32'h0});
      wb(1'b0, 6'h09, 8'h00, {1'b1, 32'h0});
      wr(6'h08, 8'h55);
      rd(6'h08, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 10'($urandom);
         d = 8'($urandom);
         b = i[0] ? 6'h18 : 6'h10;
         wr(b, v[7:0]);
         wr(b + 6'h04, {d[7:2], v[9:8]});
         rd(b, v[7:0]);
         rd(b + 6'h04, {6'h00, v[9:8]});
      end
      wr(6'h10, 8'h05);
      wb_sel_in <= 4'hE;
      wr(6'h10, 8'hAA);
      wb_sel_in <= 4'hF;
      rd(6'h10, 8'h05);
      wr(6'h14, 8'h00);
      wr(6'h18, 8'h03);
      wr(6'h1C, 8'h00);
      for (int f = 0; f < 4; f++) begin
         lvl = 1'($urandom);
         pe = (f == 0) ? lvl : (f == 3) ? ~lvl : 1'(f >> 1);
         cfg({MODE_CMP, 2'(f), lvl, 3'h1});
         repeat (3) @(posedge mclk_in);
         chk({32'h0, timer_pin_out}, {32'h0, lvl});
         ticks(6);
         repeat (3) @(posedge mclk_in);
         chk({32'h0, timer_pin_out}, {32'h0, pe});
         rd(6'h08, 8'h01);
         rd(6'h20, 8'h01);
      end
      cfg({MODE_TMR, 6'h01});
      ticks(6);
      chk({32'h0, timer_pin_oe_out}, 33'h0);
      rd(6'h20, 8'h01);
      wr(6'h18, 8'h07);
      cfg({MODE_CMP, FUNC_TOGGLE, 4'h0});
      ticks(8);
      rd(6'h20, 8'h03);
      rd(6'h08, 8'h01);
      cfg(8'h00);
      ticks(3);
      wr(6'h00, 8'h88);
      ticks(4);
      wr(6'h00, 8'h08);
      ticks(1);
      rd(6'h08, 8'h04);
      wr(6'h00, 8'h00);
      ticks(2);
      rd(6'h08, 8'h04);
      wr(6'h10, 8'h01);
      wr(6'h18, 8'h04);
      duty(8'hA8, 10);
      duty(8'hA0, 30);
      duty(8'hAC, 30);
      duty(8'h88, 0);
      rd(6'h20, 8'h03);
      duty(8'h98, 40);
      wr(6'h10, 8'h06);
      duty(8'hA8, 40);
      results();
   end
endmodule
